/* File: design/kms_pkg.sv */
// Package of constants, types and bus carrier for the key matrix scanner
//
// Behaviour
// [RQ1] Rows 1-8, columns 1-20 bound each pass
// [RQ2] Visit every configured position, 160 at most
// [RQ3] 128 kHz scan tick, full pass ~1.2 ms
// [RQ4] Idle drives all column outputs high
// [RQ5] Idle row change requests clock, starts scan
// [RQ6] Idle clears row-hit and key-index counters
// [RQ7] Row counter wraps, column steps, then scan end
// [RQ8] Key index counts every scanned position
// [RQ9] Modifier index table, others go to buffer
// [RQ10] Two-plus hits in column OR rows in
// [RQ11] Hit on earlier-hit row sets ghost status
// [RQ12] Ghosted key locked out of reporting
// [RQ13] Scan end rescans when any key seen
// [RQ14] No key: back to idle, drop request
// [RQ15] Key codes kept in 16-entry buffer
// [RQ16] Codes held until read or overflow; on overflow only the new code is dropped, held codes stay until read
// [RQ17] Row inputs synchronised, debounced, glitch filtered
// [RQ18] Host polls key status register
// [RQ19] Overflow drops new codes, sets sticky flag
`default_nettype none

package kms_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int SCAN_HZ = 128_000;
  localparam int PASS_TIME_US = 1200;
  localparam int TICK_CYC = CLK_HZ / SCAN_HZ;
  localparam int DIV_W = 10;
  localparam int DEB_CYC = 16;

  // ------------------------------------------------------------
  // Geometry and buffer
  // ------------------------------------------------------------
  localparam int MAX_ROWS = 8;
  localparam int MAX_COLS = 20;
  localparam int MAX_KEYS = 160;
  localparam int KBUF_DEPTH = 16;
  localparam int MOD_N = 4;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STS = 8'h04;
  localparam logic [7:0] REG_MASK = 8'h08;
  localparam logic [7:0] REG_KEY = 8'h0c;
  localparam logic [7:0] REG_INFO = 8'h10;
  localparam logic [7:0] REG_MODST = 8'h14;
  localparam logic [7:0] REG_MODTAB = 8'h18;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_ROWS_LSB = 4;
  localparam int CTRL_COLS_LSB = 8;
  localparam int STS_KEY_BIT = 0;
  localparam int STS_GHOST_BIT = 1;
  localparam int STS_OVF_BIT = 2;
  localparam int STS_MOD_BIT = 3;
  localparam int STS_W = 4;
  localparam int KEY_VALID_BIT = 8;
  localparam int INFO_CNT_LSB = 0;
  localparam int INFO_STATE_LSB = 8;
  localparam int INFO_IDX_LSB = 16;
  localparam logic [3:0] ROWS_RST = 4'h8;
  localparam logic [4:0] COLS_RST = 5'h14;
  localparam logic [7:0] MODTAB_RST = 8'hff;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {KMS_IDLE, KMS_SCAN, KMS_END} kms_state_e;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } kms_bus_req_s;

endpackage

`default_nettype wire

/* File: design/kms_rowfilt.sv */
// Row input synchroniser and stability filter for the key matrix scanner
`default_nettype none

module kms_rowfilt #(
  parameter int W = 8,
  parameter int STABLE = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Raw pins and filtered rows
  input wire logic [W-1:0] raw,
  output logic [W-1:0] filt
);
  import kms_pkg::*;

  localparam int CW = $clog2(STABLE + 1);

  generate
    if (STABLE < 1 || STABLE > TICK_CYC / 2) begin : g_bad_stable
      $error("kms_rowfilt: STABLE must settle well inside one scan tick");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] sync1;
    logic [W-1:0] sync2;
    logic [W-1:0] cand;
    logic [CW-1:0] cnt;
    logic [W-1:0] filt;
  } kms_filt_s;

  kms_filt_s st_q, st_d;

  // ------------------------------------------------------------
  // Filter: rows must hold one value STABLE cycles
  // ------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.sync1 = raw;
    st_d.sync2 = st_q.sync1;
    if (st_q.sync2 != st_q.cand) begin
      st_d.cand = st_q.sync2; // [RQ17]
      st_d.cnt = '0;
    end else if (st_q.cnt == CW'(STABLE)) begin
      st_d.filt = st_q.cand; // [RQ17]
    end else begin
      st_d.cnt = st_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign filt = st_q.filt;

endmodule // kms_rowfilt

`default_nettype wire

/* File: design/kms_scanner.sv */
// Key matrix scanner: scan controller, key buffer, registers and interrupt
`default_nettype none

module kms_scanner #(
  parameter int DEPTH = kms_pkg::KBUF_DEPTH,
  parameter int NMOD = kms_pkg::MOD_N,
  parameter int DEB = kms_pkg::DEB_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic srst,
  // Register port
  input wire kms_pkg::kms_bus_req_s bus_req,
  output logic [31:0] bus_rdata,
  output logic irq,
  // Matrix pins
  input wire logic [kms_pkg::MAX_ROWS-1:0] row_in,
  output logic [kms_pkg::MAX_COLS-1:0] col_out,
  // Scan clock request
  input wire logic clk_other_en,
  output logic clk_req
);
  import kms_pkg::*;

  localparam int AW = $clog2(DEPTH);

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("kms_scanner: DEPTH must be a power of two, at least 2");
    end
    if (NMOD < 1 || NMOD > 8) begin : g_bad_nmod
      $error("kms_scanner: NMOD must be 1 to 8");
    end
    if (TICK_CYC >= 2 ** DIV_W) begin : g_bad_div
      $error("kms_scanner: divider too narrow");
    end
  endgenerate

  typedef struct packed {
    kms_state_e state;
    logic cfg_en;
    logic [3:0] cfg_rows;
    logic [4:0] cfg_cols;
    logic [STS_W-1:0] mask;
    logic [STS_W-1:0] sts;
    logic [NMOD-1:0][7:0] modtab;
    logic [NMOD-1:0] modst;
    logic [DIV_W-1:0] divc;
    logic [2:0] row;
    logic [4:0] col;
    logic [7:0] keyidx;
    logic [7:0] rowhit;
    logic anykey;
    logic [MAX_ROWS-1:0] prev_rows;
    logic [MAX_KEYS-1:0] pressed;
    logic [DEPTH-1:0][7:0] kbuf;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [MAX_COLS-1:0] col_out;
    logic clk_req;
    logic irq;
    logic [31:0] rdata;
  } kms_st_s;

  kms_st_s st_q, st_d;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] popcnt(input logic [MAX_ROWS-1:0] v);
    logic [3:0] s;
    s = '0;
    for (int i = 0; i < MAX_ROWS; i++) begin
      s = s + 4'(v[i]);
    end
    return s;
  endfunction

  // Out-of-range counts fall back to the full matrix
  function automatic logic [4:0] clamp(input logic [4:0] v, input logic [4:0] mx);
    return (v == 5'h00 || v > mx) ? mx : v;
  endfunction

  // ------------------------------------------------------------
  // Row filter
  // ------------------------------------------------------------
  logic [MAX_ROWS-1:0] rows_f;

  kms_rowfilt #(
    .W(MAX_ROWS),
    .STABLE(DEB)
  ) u_rowfilt (
    .clock(clock),
    .srst(srst),
    .raw(row_in),
    .filt(rows_f)
  );

  // ------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------
  logic tick;
  logic push;
  logic pop;
  logic hit;
  logic ghost;
  logic [7:0] code;
  logic [STS_W-1:0] evt;
  logic [STS_W-1:0] clr;
  logic [4:0] nrows;
  logic [4:0] ncols;
  logic [AW:0] cnt_pop;
  logic mod_hit;

  always_comb begin
    st_d = st_q;
    tick = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    ghost = 1'b0;
    mod_hit = 1'b0;
    code = st_q.keyidx;
    evt = '0;
    clr = '0;
    nrows = clamp({1'b0, st_q.cfg_rows}, 5'(MAX_ROWS)); // [RQ1]
    ncols = clamp(st_q.cfg_cols, 5'(MAX_COLS)); // [RQ1]
    hit = rows_f[st_q.row];

    // Register writes
    if (bus_req.wr) begin
      case (bus_req.addr)
        REG_CTRL: begin
          st_d.cfg_en = bus_req.wdata[CTRL_EN_BIT];
          st_d.cfg_rows = bus_req.wdata[CTRL_ROWS_LSB +: 4];
          st_d.cfg_cols = bus_req.wdata[CTRL_COLS_LSB +: 5];
        end
        REG_STS: clr = bus_req.wdata[STS_W-1:0];
        REG_MASK: st_d.mask = bus_req.wdata[STS_W-1:0];
        default: ;
      endcase
      for (int i = 0; i < NMOD; i++) begin
        if (bus_req.addr == REG_MODTAB + 8'(4 * i)) begin
          st_d.modtab[i] = bus_req.wdata[7:0];
        end
      end
    end

    // Register reads, data in the following cycle only
    st_d.rdata = '0;
    if (bus_req.rd) begin
      case (bus_req.addr)
        REG_CTRL: begin
          st_d.rdata[CTRL_EN_BIT] = st_q.cfg_en;
          st_d.rdata[CTRL_ROWS_LSB +: 4] = st_q.cfg_rows;
          st_d.rdata[CTRL_COLS_LSB +: 5] = st_q.cfg_cols;
        end
        REG_STS: st_d.rdata[STS_W-1:0] = st_q.sts; // [RQ18]
        REG_MASK: st_d.rdata[STS_W-1:0] = st_q.mask;
        REG_KEY: begin
          if (st_q.cnt != '0) begin
            st_d.rdata[KEY_VALID_BIT:0] = {1'b1, st_q.kbuf[st_q.rp]};
            pop = 1'b1; // [RQ16]
          end
        end
        REG_INFO: begin
          st_d.rdata[INFO_CNT_LSB +: AW + 1] = st_q.cnt;
          st_d.rdata[INFO_STATE_LSB +: 2] = st_q.state;
          st_d.rdata[INFO_IDX_LSB +: 8] = st_q.keyidx;
        end
        REG_MODST: st_d.rdata[NMOD-1:0] = st_q.modst;
        default: ;
      endcase
      for (int i = 0; i < NMOD; i++) begin
        if (bus_req.addr == REG_MODTAB + 8'(4 * i)) begin
          st_d.rdata[7:0] = st_q.modtab[i];
        end
      end
    end

    // Scan tick divider, runs only while the scan clock is on
    if (st_q.state == KMS_IDLE || !(st_q.clk_req || clk_other_en)) begin
      st_d.divc = '0;
    end else if (st_q.divc == DIV_W'(TICK_CYC - 1)) begin
      st_d.divc = '0;
      tick = 1'b1; // [RQ3]
    end else begin
      st_d.divc = st_q.divc + DIV_W'(1);
    end

    // Scan controller
    case (st_q.state)
      KMS_IDLE: begin
        st_d.rowhit = '0; // [RQ6]
        st_d.keyidx = '0; // [RQ6]
        st_d.row = '0;
        st_d.col = '0;
        st_d.anykey = 1'b0;
        st_d.prev_rows = rows_f;
        if (st_q.cfg_en && rows_f != st_q.prev_rows) begin
          st_d.state = KMS_SCAN; // [RQ5]
        end
      end
      KMS_SCAN: begin
        if (tick) begin
          ghost = hit && st_q.rowhit[st_q.row]; // [RQ11]
          if (ghost) begin
            evt[STS_GHOST_BIT] = 1'b1; // [RQ11]
          end
          if (hit) begin
            st_d.anykey = 1'b1;
          end
          for (int m = 0; m < NMOD; m++) begin
            if (st_q.modtab[m] == st_q.keyidx) begin
              mod_hit = 1'b1; // [RQ9]
              st_d.modst[m] = hit && !ghost;
              if (st_d.modst[m] != st_q.modst[m]) begin
                evt[STS_MOD_BIT] = 1'b1;
              end
            end
          end
          // Ghosted keys stay unreported until the ghost clears
          st_d.pressed[st_q.keyidx] = hit && !ghost; // [RQ12]
          if (!mod_hit && hit && !ghost && !st_q.pressed[st_q.keyidx]) begin
            push = 1'b1; // [RQ9]
          end
          st_d.keyidx = st_q.keyidx + 8'h01; // [RQ8]
          if ({2'b00, st_q.row} == nrows - 5'h01) begin
            if (popcnt(rows_f) >= 4'h2) begin
              st_d.rowhit = st_q.rowhit | rows_f; // [RQ10]
            end
            st_d.row = '0; // [RQ7]
            if (st_q.col == ncols - 5'h01) begin
              st_d.state = KMS_END; // [RQ7] [RQ2]
            end else begin
              st_d.col = st_q.col + 5'h01; // [RQ7]
            end
          end else begin
            st_d.row = st_q.row + 3'h1; // [RQ7]
          end
        end
      end
      KMS_END: begin
        if (tick) begin
          st_d.row = '0;
          st_d.col = '0;
          st_d.keyidx = '0;
          st_d.rowhit = '0;
          st_d.anykey = 1'b0;
          st_d.prev_rows = rows_f;
          st_d.state = st_q.anykey ? KMS_SCAN : KMS_IDLE; // [RQ13] [RQ14]
        end
      end
      default: st_d.state = KMS_IDLE;
    endcase

    // Key code buffer
    if (pop) begin
      st_d.rp = st_q.rp + AW'(1);
    end
    cnt_pop = st_q.cnt - (AW + 1)'(pop);
    st_d.cnt = cnt_pop;
    if (push) begin
      if (cnt_pop == (AW + 1)'(DEPTH)) begin
        evt[STS_OVF_BIT] = 1'b1; // [RQ19]
      end else begin
        st_d.kbuf[st_q.wp] = code; // [RQ15]
        st_d.wp = st_q.wp + AW'(1);
        st_d.cnt = cnt_pop + (AW + 1)'(1);
        evt[STS_KEY_BIT] = 1'b1;
      end
    end

    // Sticky status, a new event wins over a clear
    st_d.sts = (st_q.sts & ~clr) | evt; // [RQ19]
    st_d.irq = |(st_d.sts & st_d.mask);
    st_d.clk_req = (st_d.state != KMS_IDLE) && !clk_other_en; // [RQ5] [RQ14]
    if (st_d.state == KMS_SCAN) begin
      st_d.col_out = MAX_COLS'(1) << st_d.col;
    end else begin
      st_d.col_out = '1; // [RQ4]
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      st_q <= '0;
      st_q.state <= KMS_IDLE;
      st_q.cfg_rows <= ROWS_RST;
      st_q.cfg_cols <= COLS_RST;
      st_q.modtab <= {NMOD{MODTAB_RST}};
      st_q.col_out <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign bus_rdata = st_q.rdata;
  assign irq = st_q.irq;
  assign col_out = st_q.col_out;
  assign clk_req = st_q.clk_req;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (srst);

  property p_idle_cols;
    st_q.state != KMS_SCAN |-> col_out == '1;
  endproperty
  a_idle_cols: assert property (p_idle_cols) else $error("columns not high outside scan"); // [RQ4]

  property p_idle_clear;
    st_q.state == KMS_IDLE ##1 st_q.state == KMS_IDLE |-> st_q.keyidx == '0 && st_q.rowhit == '0;
  endproperty
  a_idle_clear: assert property (p_idle_clear) else $error("idle counters not cleared"); // [RQ6]

  property p_req_scan;
    st_q.state != KMS_IDLE && !$past(clk_other_en) |-> clk_req;
  endproperty
  a_req_scan: assert property (p_req_scan) else $error("scan without clock request"); // [RQ5]

  property p_idle_noreq;
    st_q.state == KMS_IDLE |-> !clk_req;
  endproperty
  a_idle_noreq: assert property (p_idle_noreq) else $error("clock request held in idle"); // [RQ14]

  property p_bounds;
    st_q.state == KMS_SCAN |-> {2'b00, st_q.row} < nrows && st_q.col < ncols;
  endproperty
  a_bounds: assert property (p_bounds) else $error("scan position outside matrix"); // [RQ1]

  property p_idx_step;
    tick && st_q.state == KMS_SCAN |=> st_q.keyidx == $past(st_q.keyidx) + 8'h01;
  endproperty
  a_idx_step: assert property (p_idx_step) else $error("key index did not step"); // [RQ8]

  property p_ghost;
    tick && st_q.state == KMS_SCAN && hit && st_q.rowhit[st_q.row] |=>
      st_q.sts[STS_GHOST_BIT] && !st_q.pressed[$past(st_q.keyidx)];
  endproperty
  a_ghost: assert property (p_ghost) else $error("ghost not flagged or not locked out"); // [RQ11]

  property p_ovf;
    push && cnt_pop == (AW + 1)'(DEPTH) |=> st_q.sts[STS_OVF_BIT] && st_q.cnt == (AW + 1)'(DEPTH);
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not flagged"); // [RQ19]

  property p_end_rescan;
    tick && st_q.state == KMS_END |=> st_q.state == ($past(st_q.anykey) ? KMS_SCAN : KMS_IDLE);
  endproperty
  a_end_rescan: assert property (p_end_rescan) else $error("wrong exit from scan end"); // [RQ13]

  property p_tick_gap;
    tick |=> !tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("scan ticks too close"); // [RQ3]

endmodule // kms_scanner

`default_nettype wire

/* File: tb/kms_matrix.sv */
// Behavioural key switch matrix with row diodes and row pull-downs
`default_nettype none

module kms_matrix #(
  parameter int ROWS = 2
) (
  // Key state from the bench
  input wire logic [kms_pkg::MAX_KEYS-1:0] pressed,
  // Matrix pins
  input wire logic [kms_pkg::MAX_COLS-1:0] col_out,
  output logic [kms_pkg::MAX_ROWS-1:0] row_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import kms_pkg::*;

  // A row reads high only through a pressed key on a driven-high column
  always_comb begin
    row_in = '0;
    for (int c = 0; c < MAX_COLS; c++) begin
      for (int r = 0; r < ROWS; r++) begin
        if (col_out[c] && pressed[c*ROWS+r]) begin
          row_in[r] = 1'b1;
        end
      end
    end
  end
endmodule // kms_matrix

`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the key matrix scanner
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import kms_pkg::*;

  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  localparam int NR = 2;
  localparam int WAIT_CYC = 7 * TICK_CYC + 100;
  logic clock = 1'b0;
  logic srst = 1'b1;
  kms_bus_req_s req;
  logic [31:0] bus_rdata;
  logic irq;
  logic clk_req;
  logic clk_other_en;
  logic [MAX_ROWS-1:0] row_in;
  logic [MAX_COLS-1:0] col_out;
  logic [MAX_KEYS-1:0] pressed;
  logic [31:0] exp_q[$];
  logic rd_seen = 1'b0;
  logic [7:0] lfsr;
  int idx;
  int n_fail = 0;
  int samples_checked = 0;

  initial begin
    forever #5 clock = ~clock;
  end

  kms_scanner #(.DEPTH(2), .NMOD(4), .DEB(16)) dut (
    .clock(clock), .srst(srst), .bus_req(req), .bus_rdata(bus_rdata), .irq(irq),
    .row_in(row_in), .col_out(col_out), .clk_other_en(clk_other_en), .clk_req(clk_req)
  );

  kms_matrix #(.ROWS(NR)) mat (.pressed(pressed), .col_out(col_out), .row_in(row_in));

  // ------------------------------------------------------------
  // Checking
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      n_fail++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // Read data stand only in the cycle after the strobe
  always @(posedge clock) begin
    if (rd_seen) begin
      check(bus_rdata, exp_q.pop_front());
    end
    rd_seen <= req.rd;
  end

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Five key scenarios: hold, one idle wait of up to two passes, margin
  initial begin
    repeat (5 * (WAIT_CYC + 16 * TICK_CYC)) @(posedge clock);
    n_fail++;
    give_verdict();
  end

  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clock);
    req.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] want);
    @(posedge clock);
    req.addr <= a;
    req.rd <= 1'b1;
    exp_q.push_back(want);
    @(posedge clock);
    req.rd <= 1'b0;
  endtask

  // Hold a key set through one pass and scan end of the 2 x 3 matrix
  task automatic press(input logic [MAX_KEYS-1:0] keys);
    @(posedge clock);
    pressed <= keys;
    repeat (WAIT_CYC) @(posedge clock);
  endtask

  // Release all keys; idle shows as columns high for longer than the end state
  task automatic wait_idle();
    int run = 0;
    @(posedge clock);
    pressed <= '0;
    for (int k = 0; k < 40000 && run < 2 * TICK_CYC; k++) begin
      @(posedge clock);
      run = (col_out === '1) ? run + 1 : 0;
    end
    check(32'(run >= 2 * TICK_CYC), 32'h1);
    check(col_out, {MAX_COLS{1'b1}});
    check(clk_req, 32'h0);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  initial begin
    req = '0;
    pressed = '0;
    clk_other_en = 1'b0;
    lfsr = 8'h04;
    repeat (20) @(posedge clock);
    srst <= 1'b0;
    check(col_out, {MAX_COLS{1'b1}});
    check(clk_req, 32'h0);
    bus_rd(REG_CTRL, 32'h0000_1480);
    bus_rd(REG_MODTAB, 32'h0000_00ff);
    bus_rd(8'h40, 32'h0);
    bus_wr(REG_CTRL, 32'h0000_0321);
    bus_wr(REG_MASK, 32'h0);
    // Single random key, with and without another scan clock user
    for (int i = 0; i < 2; i++) begin
      lfsr = lfsr_next(lfsr);
      idx = lfsr % 6;
      @(posedge clock);
      clk_other_en <= lfsr[0];
      press(MAX_KEYS'(1) << idx);
      check(clk_req, {31'h0, ~lfsr[0]});
      check(irq, 32'(i));
      if (i == 0) begin
        bus_wr(REG_MASK, 32'hf);
        repeat (2) @(posedge clock);
        check(irq, 32'h1);
      end
      bus_rd(REG_KEY, 32'h100 | idx);
      bus_rd(REG_KEY, 32'h0);
      bus_wr(REG_STS, 32'h1);
      repeat (2) @(posedge clock);
      check(irq, 32'h0);
      wait_idle();
    end
    // Two hits in column 0, then a hit on an already hit row in column 1
    press(MAX_KEYS'(32'h7));
    bus_rd(REG_STS, 32'h3);
    bus_rd(REG_KEY, 32'h100);
    bus_rd(REG_KEY, 32'h101);
    bus_rd(REG_KEY, 32'h0);
    wait_idle();
    bus_wr(REG_STS, 32'hf);
    // Three new keys into a two-entry buffer
    press(MAX_KEYS'(32'h19));
    bus_rd(REG_STS, 32'h5);
    bus_rd(REG_KEY, 32'h100);
    bus_rd(REG_KEY, 32'h103);
    bus_rd(REG_KEY, 32'h0);
    wait_idle();
    bus_wr(REG_STS, 32'hf);
    bus_rd(REG_STS, 32'h0);
    // A modifier key bypasses the buffer
    bus_wr(REG_MODTAB, 32'h5);
    press(MAX_KEYS'(32'h20));
    bus_rd(REG_STS, 32'h8);
    bus_rd(REG_MODST, 32'h1);
    bus_rd(REG_KEY, 32'h0);
    wait_idle();
    bus_rd(REG_INFO, 32'h0);
    repeat (4) @(posedge clock);
    give_verdict();
  end
endmodule // tb

`default_nettype wire
